// [rtl/rtcp_device.sv]
// Purpose: device end of the three-wire command port
// Assumes: link pins are asynchronous and pass two flops
// Notes:   register storage is outside; writes and reads use a user port
//
// Function
// R01 - first byte after enable is command
// R02 - marker bit zero blocks writes
// R03 - command bit 6 selects clock or RAM
// R04 - command bits 1..5 give register address
// R05 - command bit 0: write zero, read one
// R06 - command byte assembled LSB first
// R07 - enable high activates control and shifter
// R08 - enable low aborts and releases pin
// R09 - bit period is fall then rise
// R10 - sample on rise, drive on fall
// R11 - host holds clock low at enable rise
// R12 - eight data bits captured after write command
// R13 - extra cycles after single write ignored
// R14 - write data assembled LSB first
// R15 - read bits driven from first following fall
// R16 - reads continue as bursts while enabled
// R17 - pin tri-stated on every rising edge
// R18 - address all ones means burst from zero
// R19 - command bit 1 is address LSB
`timescale 1ns/1ps
module rtcp_device (
    input  wire logic       clock,
    input  wire logic       arst_n,
    rtcp_if.dev             link,
    output logic            wrStb,
    output logic            rdStb,
    output logic            spaceSelect,
    output logic [4:0]      regAddr,
    output logic [7:0]      wrData,
    input  wire logic [7:0] rdData
);
    typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD, ST_DONE} rtcp_state_t;
    typedef struct packed {
        logic [1:0]  ceSync;
        logic [1:0]  ckSync;
        logic [1:0]  dSync;
        logic        ckPrev;
        rtcp_state_t st;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic [7:0]  outSh;
        logic        burst;
        logic        marker;
        logic        space;
        logic [4:0]  addr;
        logic [7:0]  wdat;
        logic        wrStb;
        logic        rdStb;
        logic        dout;
        logic        doeN;
        logic        armRd;
    } rtcp_dev_t;
    rtcp_dev_t s_r, s_nxt;
    logic ce, ck, din, rise, fall;
    logic [7:0] cmdNow;
    // ==========================================
    // synchronised link levels; first flops feed only second
    assign ce   = s_r.ceSync[1];
    assign ck   = s_r.ckSync[1];
    assign din  = s_r.dSync[1];
    assign rise = ck & ~s_r.ckPrev;   // R10
    assign fall = ~ck & s_r.ckPrev;   // R09
    assign cmdNow = {din, s_r.shift[7:1]};
    // ==========================================
    // next-state logic
    always_comb begin
        s_nxt        = s_r;
        s_nxt.ceSync = {s_r.ceSync[0], link.xferEn};
        s_nxt.ckSync = {s_r.ckSync[0], link.sclk};
        s_nxt.dSync  = {s_r.dSync[0], link.dataIn};
        s_nxt.ckPrev = ck;
        s_nxt.wrStb  = 1'b0;
        s_nxt.rdStb  = 1'b0;
        if (!ce) begin
            // abort whatever is in flight and float the pin
            s_nxt.st     = ST_CMD;                                   // R08
            s_nxt.bitCnt = rtcp_pkg::COUNT_RESET;
            s_nxt.doeN   = 1'b1;                                     // R08
            s_nxt.armRd  = 1'b0;
        end else begin                                               // R07
            if (rise) begin
                s_nxt.doeN = 1'b1;                                   // R17
            end
            case (s_r.st)
                ST_CMD: begin
                    if (rise) begin
                        s_nxt.shift  = cmdNow;                       // R06
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                        if (s_r.bitCnt == 4'(rtcp_pkg::BYTE_BITS - 1)) begin  // R01
                            s_nxt.bitCnt = rtcp_pkg::COUNT_RESET;
                            s_nxt.marker = cmdNow[rtcp_pkg::CMD_MARKER_BIT];
                            s_nxt.space  = cmdNow[rtcp_pkg::CMD_SPACE_BIT];   // R03
                            // bit 1 is the address lsb
                            s_nxt.addr   = cmdNow[rtcp_pkg::CMD_ADDR_MSB:
                                                  rtcp_pkg::CMD_ADDR_LSB];    // R04 R19
                            s_nxt.burst  = (cmdNow[rtcp_pkg::CMD_ADDR_MSB:
                                                   rtcp_pkg::CMD_ADDR_LSB]
                                            == rtcp_pkg::BURST_ADDR);         // R18
                            if (cmdNow[rtcp_pkg::CMD_ADDR_MSB:rtcp_pkg::CMD_ADDR_LSB]
                                == rtcp_pkg::BURST_ADDR) begin
                                s_nxt.addr = 5'h00;                           // R18
                            end
                            if (cmdNow[rtcp_pkg::CMD_DIR_BIT]) begin          // R05
                                s_nxt.st    = ST_RD;
                                s_nxt.rdStb = 1'b1;
                                s_nxt.armRd = 1'b1;
                            end else begin
                                s_nxt.st    = ST_WR;
                            end
                        end
                    end
                end
                ST_WR: begin
                    // step only after the strobe, so each byte lands at its own address
                    if (s_r.wrStb && s_r.burst) begin
                        s_nxt.addr = s_r.addr + 5'h01;
                    end
                    if (rise) begin
                        s_nxt.shift  = cmdNow;                       // R14
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                        if (s_r.bitCnt == 4'(rtcp_pkg::BYTE_BITS - 1)) begin  // R12
                            s_nxt.bitCnt = rtcp_pkg::COUNT_RESET;
                            s_nxt.wdat   = cmdNow;
                            s_nxt.wrStb  = s_r.marker;               // R02
                            s_nxt.st     = s_r.burst ? ST_WR : ST_DONE;  // R13
                        end
                    end
                end
                ST_RD: begin
                    // byte from the user port lands one cycle after rdStb
                    if (s_r.armRd && !s_r.rdStb) begin
                        s_nxt.outSh = rdData;
                        s_nxt.armRd = 1'b0;
                    end
                    if (fall) begin
                        s_nxt.dout   = s_r.outSh[0];                 // R15
                        s_nxt.outSh  = {1'b0, s_r.outSh[7:1]};
                        s_nxt.doeN   = 1'b0;                         // R10
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                        if (s_r.bitCnt == 4'(rtcp_pkg::BYTE_BITS - 1)) begin  // R16
                            s_nxt.bitCnt = rtcp_pkg::COUNT_RESET;
                            // single reads resend the same byte; bursts move on
                            if (s_r.burst) begin
                                s_nxt.addr = s_r.addr + 5'h01;       // R16
                            end
                            s_nxt.rdStb  = 1'b1;
                            s_nxt.armRd  = 1'b1;
                        end
                    end
                end
                default: begin
                    // single write finished: clocks are ignored
                end
            endcase
        end
    end
    // ==========================================
    // single state register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_r      <= '0;
            s_r.st   <= ST_CMD;
            s_r.doeN <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    // ==========================================
    // outputs
    assign link.devDout  = s_r.dout;
    assign link.devDoeN  = s_r.doeN;
    assign wrStb         = s_r.wrStb;
    assign rdStb         = s_r.rdStb;
    assign spaceSelect   = s_r.space;
    assign regAddr       = s_r.addr;
    assign wrData        = s_r.wdat;
endmodule

// [rtl/rtcp_host.sv]
// Purpose: host end driving the three-wire command port
// Assumes: one command at a time from the user port
// Notes:   shift clock made by a divider from the system clock
`timescale 1ns/1ps
module rtcp_host (
    input  wire logic       clock,
    input  wire logic       arst_n,
    rtcp_if.host            link,
    input  wire logic       start,
    input  wire logic [7:0] cmd,
    input  wire logic [7:0] txData,
    output logic            busy,
    output logic            rxValid,
    output logic [7:0]      rxData
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_SHIFT, H_END} rtcp_hst_t;
    typedef struct packed {
        logic [1:0] dSync;
        rtcp_hst_t  st;
        logic [7:0] div;
        logic [4:0] bitCnt;
        logic [15:0] tx;
        logic        rd;
        logic        ce;
        logic        ck;
        logic        dout;
        logic        doeN;
        logic [7:0]  rx;
        logic        rxV;
    } rtcp_host_t;
    rtcp_host_t s_r, s_nxt;
    logic       lastBit;
    assign lastBit = (s_r.bitCnt == 5'd15);
    // ==========================================
    // sequencer: clock low at enable rise, data set up before each rise
    always_comb begin
        s_nxt       = s_r;
        s_nxt.dSync = {s_r.dSync[0], link.dataIn};
        s_nxt.rxV   = 1'b0;
        case (s_r.st)
            H_IDLE: begin
                if (start) begin
                    s_nxt.tx     = {txData, cmd};
                    s_nxt.rd     = cmd[rtcp_pkg::CMD_DIR_BIT];
                    s_nxt.ce     = 1'b1;                      // R07 R11
                    s_nxt.ck     = 1'b0;
                    s_nxt.bitCnt = 5'd0;
                    s_nxt.div    = 8'(rtcp_pkg::CE_SETUP_CYC);
                    s_nxt.dout   = cmd[0];                    // R06
                    s_nxt.doeN   = 1'b0;
                    s_nxt.st     = H_SETUP;
                end
            end
            H_SETUP: begin
                s_nxt.div = s_r.div - 8'd1;
                if (s_r.div == 8'd0) begin
                    s_nxt.st  = H_SHIFT;
                    s_nxt.div = 8'(rtcp_pkg::SCLK_HALF_CYC);
                end
            end
            H_SHIFT: begin
                s_nxt.div = s_r.div - 8'd1;
                if (s_r.div == 8'd0) begin
                    s_nxt.div = 8'(rtcp_pkg::SCLK_HALF_CYC);
                    s_nxt.ck  = ~s_r.ck;
                    if (!s_r.ck) begin
                        // rising edge: sample read bits late in the low phase
                        if (s_r.rd && s_r.bitCnt >= 5'd8) begin
                            s_nxt.rx = {s_r.dSync[1], s_r.rx[7:1]};
                        end
                    end else begin
                        // falling edge: next bit, lsb first
                        s_nxt.bitCnt = s_r.bitCnt + 5'd1;
                        s_nxt.tx     = {1'b0, s_r.tx[15:1]};   // R14
                        s_nxt.dout   = s_r.tx[1];
                        if (s_r.rd && s_r.bitCnt >= 5'd7) begin
                            s_nxt.doeN = 1'b1;
                        end
                        if (lastBit) begin
                            // drop enable with the last fall so the device sees
                            // both in one cycle and never drives a stray bit
                            s_nxt.ce  = 1'b0;                          // R08
                            s_nxt.st  = H_END;
                            s_nxt.rxV = s_r.rd;
                        end
                    end
                end
            end
            default: begin
                s_nxt.ce   = 1'b0;
                s_nxt.doeN = 1'b1;
                s_nxt.st   = H_IDLE;
            end
        endcase
    end
    // ==========================================
    // state register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_r      <= '0;
            s_r.st   <= H_IDLE;
            s_r.doeN <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign link.xferEn   = s_r.ce;
    assign link.sclk     = s_r.ck;
    assign link.hostDout = s_r.dout;
    assign link.hostDoeN = s_r.doeN;
    assign busy          = (s_r.st != H_IDLE);
    assign rxValid       = s_r.rxV;
    assign rxData        = s_r.rx;
endmodule

// [rtl/rtcp_if.sv]
// Purpose: three-wire link between host and device
// Assumes: data pin resolved by the bench from the two enables
// Notes:   output enables are active low
`timescale 1ns/1ps
interface rtcp_if;
    logic xferEn;      // transfer enable, host driven
    logic sclk;        // shift clock, host driven
    logic hostDout;    // host data out
    logic hostDoeN;    // host drives data pin when low
    logic devDout;     // device data out
    logic devDoeN;     // device drives data pin when low
    logic dataIn;      // resolved pin level
    modport host (output xferEn, output sclk, output hostDout, output hostDoeN,
                  input dataIn);
    modport dev  (input xferEn, input sclk, output devDout, output devDoeN,
                  input dataIn);
endinterface

// [rtl/rtcp_pkg.sv]
// Purpose: shared constants and types for the three-wire command port
// Assumes: both ends run on one 200 MHz system clock
// Notes:   command byte and link timing constants live here
package rtcp_pkg;
    // ==========================================
    // command byte layout
    localparam int CMD_DIR_BIT    = 0;
    localparam int CMD_ADDR_LSB   = 1;
    localparam int CMD_ADDR_MSB   = 5;
    localparam int CMD_SPACE_BIT  = 6;
    localparam int CMD_MARKER_BIT = 7;
    localparam logic [4:0] BURST_ADDR = 5'h1F;
    localparam int BYTE_BITS      = 8;
    // ==========================================
    // link timing (host side divider)
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int SCLK_HALF_NS   = 250;
    localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CE_SETUP_NS    = 1000;
    localparam int CE_SETUP_CYC   = (CE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ==========================================
    // reset values
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic [3:0] COUNT_RESET = 4'h0;
endpackage

// [sim/rtcp_assertions.sv]
// Purpose: wire-level checks on the three-wire link between both ends
// Assumes: signals taken straight from the interface, one clock domain
// Notes:   the rise counter restarts whenever enable is low
`timescale 1ns/1ps
module rtcp_assertions (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic xferEn,
    input wire logic sclk,
    input wire logic hostDout,
    input wire logic hostDoeN,
    input wire logic devDout,
    input wire logic devDoeN,
    input wire logic dataIn
);
    logic       sclkQ;
    logic [4:0] riseCnt;

    // ==========================================
    // shift clock rises in the current frame; saturates so it never wraps
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclkQ   <= 1'b0;
            riseCnt <= 5'h00;
        end else begin
            sclkQ <= sclk;
            if (!xferEn) begin
                riseCnt <= 5'h00;
            end else if (sclk && !sclkQ && riseCnt != 5'h1F) begin
                riseCnt <= riseCnt + 5'h01;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // ==========================================
    // link rules
    chk_pin_release: assert property ((!xferEn) [*4] |-> devDoeN)
        else $error("device drives data pin while enable low");
    chk_clk_low_start: assert property ($rose(xferEn) |-> !sclk ##1 (!sclk) [*8])
        else $error("shift clock not low at enable rise");
    chk_host_data_hold: assert property ($rose(sclk) |-> $stable(hostDout))
        else $error("host data changed at shift clock rise");
    chk_dev_change_low: assert property (
        ($changed(devDout) || $fell(devDoeN)) && !devDoeN |-> !sclk)
        else $error("device data changed while shift clock high");
    chk_float_on_rise: assert property ($rose(sclk) |-> ##[0:4] devDoeN)
        else $error("device data pin not released after rise");
    chk_no_contention: assert property (!(!hostDoeN && !devDoeN))
        else $error("both ends drive the data pin");
    chk_read_after_cmd: assert property (!devDoeN |-> riseCnt >= 5'h08)
        else $error("device drives before command byte complete");
    chk_frame_bits: assert property (xferEn |-> riseCnt <= 5'h10)
        else $error("more than sixteen bit cycles in a frame");

    cover property ($fell(devDoeN));
    cover property (riseCnt == 5'h10);
    cover property ($rose(xferEn));
endmodule

// [sim/testbench.sv]
// Purpose: end-to-end bench for host and device ends of the command port
// Assumes: device register contents modelled as a plain function of address
// Notes:   host sends single bytes only, so burst shows at device strobes
`timescale 1ns/1ps
module testbench;
    logic       clock     = 1'b0;
    logic       arst_n    = 1'b0;
    logic       start     = 1'b0;
    logic [7:0] cmd       = 8'h00;
    logic [7:0] txData    = 8'h00;
    logic [7:0] rdData    = 8'h00;
    logic [7:0] lastWr    = 8'h00;
    logic [7:0] lastRx    = 8'h00;
    logic [5:0] lastAddr  = 6'h00;
    logic       busy;
    logic       rxValid;
    logic [7:0] rxData;
    logic       wrStb;
    logic       rdStb;
    logic       spaceSelect;
    logic [4:0] regAddr;
    logic [7:0] wrData;
    int         wrCount   = 0;
    int         err_total = 0;
    int         tests_run = 0;

    always #2.5 clock = ~clock;

    rtcp_if link ();
    // pin has a pull-down, so nobody driving reads as zero
    assign link.dataIn = !link.hostDoeN ? link.hostDout :
                         (!link.devDoeN ? link.devDout : 1'b0);

    rtcp_host rtcp_host_inst (.clock(clock), .arst_n(arst_n), .link(link), .start(start),
        .cmd(cmd), .txData(txData), .busy(busy), .rxValid(rxValid), .rxData(rxData));
    rtcp_device rtcp_device_inst (.clock(clock), .arst_n(arst_n), .link(link),
        .wrStb(wrStb), .rdStb(rdStb), .spaceSelect(spaceSelect), .regAddr(regAddr),
        .wrData(wrData), .rdData(rdData));
    rtcp_assertions rtcp_assertions_inst (.clock(clock), .arst_n(arst_n),
        .xferEn(link.xferEn), .sclk(link.sclk), .hostDout(link.hostDout),
        .hostDoeN(link.hostDoeN), .devDout(link.devDout), .devDoeN(link.devDoeN),
        .dataIn(link.dataIn));

    // ==========================================
    // device user port: read byte stands the cycle after its strobe
    always @(posedge clock) begin
        if (rdStb === 1'b1) rdData <= {3'h5, regAddr};
        if ((wrStb | rdStb) === 1'b1) lastAddr <= {spaceSelect, regAddr};
        if (wrStb === 1'b1) wrCount <= wrCount + 1;
        if (wrStb === 1'b1) lastWr <= wrData;
        if (rxValid === 1'b1) lastRx <= rxData;
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one host transfer; bounded wait so a stuck busy cannot hang the run
    task automatic transfer(input logic [7:0] c, input logic [7:0] d);
        int n;
        @(posedge clock);
        start  <= 1'b1;
        cmd    <= c;
        txData <= d;
        @(posedge clock);
        start <= 1'b0;
        // busy only rises after this edge has been registered
        @(negedge clock);
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        check8("busy", 8'h00, {7'h00, busy});
        repeat (8) @(posedge clock);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        transfer(8'h94, 8'hA5);
        check8("write count", 8'h01, 8'(wrCount));
        check8("write data", 8'hA5, lastWr);
        check8("write target", 8'h0A, {2'h0, lastAddr});
        transfer(8'hC2, 8'h3C);
        check8("ram data", 8'h3C, lastWr);
        check8("ram target", 8'h21, {2'h0, lastAddr});
        transfer(8'h14, 8'h77);
        check8("refused write", 8'h02, 8'(wrCount));
        transfer(8'h95, 8'h00);
        check8("read target", 8'h0A, {2'h0, lastAddr});
        check8("read data", 8'hAA, lastRx);
        transfer(8'hFF, 8'h00);
        check8("burst target", 8'h21, {2'h0, lastAddr});
        check8("burst data", 8'hA0, lastRx);
        check8("no write on read", 8'h02, 8'(wrCount));
        complete_run();
    end
endmodule
